// ---- hw/afe_front_end.sv ----
// front end digital interface: setting words and nibble sample port
// Operation
// - frame is 16 bits: start, 12 data, 3-bit id
// - sample on strobe fall, b15 first, 16 stops
// - test words latched, zeroed while test pin low
// - id 000: attenuation, input select, receive gain
// - receive word bits 6:5 do not affect routeLt
// - id 001: transmit gains and three general outputs
// - id 010: loopbacks, tuning DAC enable, reserved bit
// - config: oversample ratio, low and high corners
// - id 011: 8-bit tuning current, reset 0x80
// - id 100: twelve analog power-down bits
// - id 101: test output and filter input selects
// - id 110: input selects and tuning frequency
// - 16-bit sample over four lines, four nibbles
// - least significant nibble first, line k bit 4n+k
// - half ratio: nibble clock out, periods doubled
// - device makes nibble clock and word signal
// - transmit samples clamped, three low bits dropped
// - converter result sign extended, two zero bits
// - power-down keeps settings, stops transmit sampling
// - reset holds clock outputs high, outputs defined
// - reset: ratio four, gains minimum, DAC off
// - site pin chooses filter routing after reset
`timescale 1ns/1ps

module afe_front_end (
   // clock and reset
   input wire logic linkClk,
   input wire logic nrst,
   // link
   afe_link_if.device lnk,
   // pins
   input wire logic powerDown,
   input wire logic testPin,
   input wire logic siteSelect,
   // converter side
   input wire logic [12:0] adcResult,
   output logic [11:0] dacTx,
   output logic [11:0] dacEcho,
   output logic dacValid,
   // settings
   output logic [11:0] rxSettings,
   output logic [11:0] txSettings,
   output logic [11:0] feConfig,
   output logic [11:0] oscTune,
   output logic [11:0] testPowerDown,
   output logic [11:0] testOutSelect,
   output logic [11:0] testInSelect,
   output logic [2:0] generalOut,
   output logic analogStop,
   output logic routeLt
);

   afe_pkg::dev_type q, d;

   function automatic logic [15:0] clampSample(input logic [15:0] v);
      logic [15:0] r;
      r = v;
      if (!v[15] && v[14]) begin
         r = `SMP_POS_MAX;
      end else if (v[15] && !v[14]) begin
         r = `SMP_NEG_MAX;
      end
      return r;
   endfunction

   logic strobeFall;
   logic bitIn;
   logic pdSync;
   logic testSync;
   logic siteSync;
   logic osrHalf;
   logic adv;
   logic [1:0] slot;
   logic [15:0] txFull;
   logic [15:0] echoFull;
   logic [15:0] txClamped;
   logic [15:0] echoClamped;

   always_comb begin
      d = q;
      d.sync1 = {lnk.wordStrobe, lnk.serialIn, powerDown, testPin, siteSelect};
      d.sync2 = q.sync1;
      d.strobeOld = q.sync2[4];
      strobeFall = q.strobeOld & ~q.sync2[4];
      bitIn = q.sync2[3];
      pdSync = q.sync2[2];
      testSync = q.sync2[1];
      siteSync = q.sync2[0];
      d.dacValid = 1'b0;
      d.analogStop = pdSync;

      // control frame receiver
      if (strobeFall) begin
         case (q.cst)
            afe_pkg::CTRL_IDLE: begin
               if (!bitIn) begin
                  d.cst = afe_pkg::CTRL_DATA;
                  d.bitCnt = 4'h0;
               end
            end
            afe_pkg::CTRL_DATA: begin
               d.shift = {q.shift[13:0], bitIn};
               if (q.bitCnt == `CTRL_LAST_DATA) begin
                  d.cst = afe_pkg::CTRL_STOP;
                  d.stopCnt = 4'h0;
               end else begin
                  d.bitCnt = q.bitCnt + 4'h1;
               end
            end
            afe_pkg::CTRL_STOP: begin
               if (!bitIn) begin
                  d.cst = afe_pkg::CTRL_DATA;
                  d.bitCnt = 4'h0;
               end else if (q.stopCnt == `CTRL_LAST_STOP) begin
                  d.cst = afe_pkg::CTRL_IDLE;
                  if (q.shift[2:0] != `ID_RSVD) begin
                     d.words[q.shift[2:0]] = q.shift[14:3];
                  end
               end else begin
                  d.stopCnt = q.stopCnt + 4'h1;
               end
            end
            default: begin
               d.cst = afe_pkg::CTRL_IDLE;
            end
         endcase
      end

      // test words always kept, applied only with test pin high
      d.testPd = testSync ? d.words[`ID_PD] : `RST_TEST;
      d.testOut = testSync ? d.words[`ID_TOUT] : `RST_TEST;
      d.testIn = testSync ? d.words[`ID_TIN] : `RST_TEST;

      // routing caught once after reset release
      if (!q.routeDone) begin
         d.routeLt = siteSync;
         d.routeDone = 1'b1;
      end

      // nibble timing
      osrHalf = q.words[`ID_CFG][`CFG_OSR_BIT];
      d.nibClk = osrHalf ? ~q.nibClk : 1'b0;
      adv = ~osrHalf | q.nibClk;
      slot = q.dcnt - 2'h1;
      txFull = {lnk.txNibble, q.txAsm[2], q.txAsm[1], q.txAsm[0]};
      echoFull = {lnk.echoNibble, q.echoAsm[2], q.echoAsm[1], q.echoAsm[0]};
      txClamped = clampSample(txFull);
      echoClamped = clampSample(echoFull);
      if (adv) begin
         d.dcnt = q.dcnt + 2'h1;
         if (q.dcnt == 2'h0) begin
            if (!pdSync) begin
               d.dacTx = txClamped[14:3];
               d.dacEcho = echoClamped[14:3];
               d.dacValid = 1'b1;
            end
         end else if (!pdSync) begin
            d.txAsm[slot] = lnk.txNibble;
            d.echoAsm[slot] = lnk.echoNibble;
         end
         if (d.dcnt == 2'h0) begin
            if (q.words[`ID_CFG][`CFG_DLOOP_BIT]) begin
               d.rxHold = {d.dacTx[11], d.dacTx, 3'h0};
            end else begin
               d.rxHold = {adcResult[12], adcResult, 2'h0};
            end
         end
         d.word = (d.dcnt == 2'h0);
         d.rxNib = d.rxHold[{d.dcnt, 2'h0} +: 4];
      end

      if (!nrst) begin
         d = '0;
         d.sync1 = {lnk.wordStrobe, lnk.serialIn, powerDown, testPin, siteSelect};
         d.sync2 = q.sync1;
         d.strobeOld = q.sync2[4];
         d.cst = afe_pkg::CTRL_IDLE;
         d.words[`ID_RX] = `RST_RX;
         d.words[`ID_TX] = `RST_TX;
         d.words[`ID_CFG] = `RST_CFG;
         d.words[`ID_TUNE] = `RST_TUNE;
         d.words[`ID_PD] = `RST_TEST;
         d.words[`ID_TOUT] = `RST_TEST;
         d.words[`ID_TIN] = `RST_TEST;
         d.nibClk = 1'b1;
         d.word = 1'b1;
      end
   end

   always_ff @(posedge linkClk) begin
      q <= d;
   end

   assign lnk.nibbleClk = q.nibClk;
   assign lnk.wordSignal = q.word;
   assign lnk.rxNibble = q.rxNib;
   assign dacTx = q.dacTx;
   assign dacEcho = q.dacEcho;
   assign dacValid = q.dacValid;
   assign rxSettings = q.words[`ID_RX];
   assign txSettings = q.words[`ID_TX];
   assign feConfig = q.words[`ID_CFG];
   assign oscTune = q.words[`ID_TUNE];
   assign testPowerDown = q.testPd;
   assign testOutSelect = q.testOut;
   assign testInSelect = q.testIn;
   assign generalOut = q.words[`ID_TX][`TX_GPO_MSB:`TX_GPO_LSB];
   assign analogStop = q.analogStop;
   assign routeLt = q.routeLt;

endmodule // afe_front_end

// ---- hw/afe_params.svh ----
// constants for the front end control and sample ports
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH

// control frame
`define CTRL_FRAME_BITS 6'h10
`define CTRL_STOP_BITS 6'h10
`define CTRL_LAST_DATA 4'hE
`define CTRL_LAST_STOP 4'hF
`define CTRL_SEQ_BITS 6'h20

// setting word identifiers
`define ID_RX 3'h0
`define ID_TX 3'h1
`define ID_CFG 3'h2
`define ID_TUNE 3'h3
`define ID_PD 3'h4
`define ID_TOUT 3'h5
`define ID_TIN 3'h6
`define ID_RSVD 3'h7

// reset values, word bit 11 carries frame bit 14
`define RST_RX 12'h000
`define RST_TX 12'h000
`define RST_CFG 12'h678
`define RST_TUNE 12'h800
`define RST_TEST 12'h000

// field positions inside a word
`define CFG_DLOOP_BIT 11
`define CFG_OSR_BIT 7
`define TX_GPO_MSB 3
`define TX_GPO_LSB 1

// sample format
`define SMP_POS_MAX 16'h3FFF
`define SMP_NEG_MAX 16'hC000

// control strobe divider of the host
`define STROBE_DIV_MSB 2
`define STROBE_EDGE 3'h3

`endif

// ---- hw/afe_pkg.sv ----
// types shared by both ends of the front end link
`include "afe_params.svh"

package afe_pkg;

   typedef enum logic [1:0] {CTRL_IDLE, CTRL_DATA, CTRL_STOP} ctrlState_type;

   typedef struct packed {
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic strobeOld;
      ctrlState_type cst;
      logic [3:0] bitCnt;
      logic [3:0] stopCnt;
      logic [14:0] shift;
      logic [6:0][11:0] words;
      logic [11:0] testPd;
      logic [11:0] testOut;
      logic [11:0] testIn;
      logic routeLt;
      logic routeDone;
      logic analogStop;
      logic nibClk;
      logic word;
      logic [1:0] dcnt;
      logic [3:0] rxNib;
      logic [15:0] rxHold;
      logic [2:0][3:0] txAsm;
      logic [2:0][3:0] echoAsm;
      logic [11:0] dacTx;
      logic [11:0] dacEcho;
      logic dacValid;
   } dev_type;

   typedef struct packed {
      logic [2:0] div;
      logic strobe;
      logic serial;
      logic [31:0] sh;
      logic [5:0] bitsLeft;
      logic cmdReady;
   } hostCore_type;

   typedef struct packed {
      logic rst1;
      logic rst2;
      logic hr1;
      logic hr2;
      logic [1:0] cnt;
      logic [15:0] rxAcc;
      logic [15:0] rxSample;
      logic rxValid;
      logic [15:0] txHold;
      logic [15:0] echoHold;
      logic [3:0] txNib;
      logic [3:0] echoNib;
      logic take;
   } hostLink_type;

endpackage

// ---- hw/afe_link_if.sv ----
// link wires between the signal processor and the front end
`timescale 1ns/1ps

interface afe_link_if;
   // control port
   logic wordStrobe;
   logic serialIn;
   // sample port
   logic nibbleClk;
   logic wordSignal;
   logic [3:0] rxNibble;
   logic [3:0] txNibble;
   logic [3:0] echoNibble;

   modport device (
      input wordStrobe,
      input serialIn,
      output nibbleClk,
      output wordSignal,
      output rxNibble,
      input txNibble,
      input echoNibble
   );

   modport host (
      output wordStrobe,
      output serialIn,
      input nibbleClk,
      input wordSignal,
      input rxNibble,
      output txNibble,
      output echoNibble
   );
endinterface

// ---- hw/afe_dsp_end.sv ----
// signal processor end: setting frames out, sample nibbles both ways
`timescale 1ns/1ps

module afe_dsp_end (
   // clocks and reset
   input wire logic core_clk,
   input wire logic linkClk,
   input wire logic nrst,
   // link
   afe_link_if.host lnk,
   // setting commands, core_clk domain
   input wire logic cmdValid,
   input wire logic [2:0] cmdId,
   input wire logic [11:0] cmdData,
   output logic cmdReady,
   // samples, linkClk domain
   input wire logic halfRate,
   input wire logic [15:0] txSample,
   input wire logic [15:0] echoSample,
   output logic sampleTake,
   output logic [15:0] rxSample,
   output logic rxValid
);

   afe_pkg::hostCore_type cq, cd;
   afe_pkg::hostLink_type lq, ld;

   logic adv;
   logic [1:0] idx;
   logic [15:0] txSrc;
   logic [15:0] echoSrc;

   // frame shifter on core_clk
   always_comb begin
      cd = cq;
      cd.div = cq.div + 3'h1;
      cd.strobe = cd.div[`STROBE_DIV_MSB];
      if (cq.cmdReady && cmdValid) begin
         cd.sh = {1'b0, cmdData, cmdId, 16'hFFFF};
         cd.bitsLeft = `CTRL_SEQ_BITS;
      end else if (cq.div == `STROBE_EDGE && cq.bitsLeft != 6'h00) begin
         cd.serial = cq.sh[31];
         cd.sh = {cq.sh[30:0], 1'b1};
         cd.bitsLeft = cq.bitsLeft - 6'h01;
      end else if (cq.div == `STROBE_EDGE) begin
         cd.serial = 1'b1;
      end
      cd.cmdReady = (cd.bitsLeft == 6'h00);
      if (!nrst) begin
         cd = '0;
         cd.serial = 1'b1;
         cd.sh = 32'hFFFFFFFF;
      end
   end

   always_ff @(posedge core_clk) begin
      cq <= cd;
   end

   // nibble port on linkClk
   always_comb begin
      ld = lq;
      ld.rst1 = nrst;
      ld.rst2 = lq.rst1;
      ld.hr1 = halfRate;
      ld.hr2 = lq.hr1;
      ld.rxValid = 1'b0;
      ld.take = 1'b0;
      adv = ~lq.hr2 | lnk.nibbleClk;
      idx = lnk.wordSignal ? 2'h0 : lq.cnt;
      txSrc = (idx == 2'h0) ? txSample : lq.txHold;
      echoSrc = (idx == 2'h0) ? echoSample : lq.echoHold;
      if (adv) begin
         ld.cnt = idx + 2'h1;
         ld.rxAcc = {lnk.rxNibble, lq.rxAcc[15:4]};
         if (idx == 2'h3) begin
            ld.rxSample = ld.rxAcc;
            ld.rxValid = 1'b1;
         end
         if (idx == 2'h0) begin
            ld.txHold = txSample;
            ld.echoHold = echoSample;
            ld.take = 1'b1;
         end
         ld.txNib = txSrc[{idx, 2'h0} +: 4];
         ld.echoNib = echoSrc[{idx, 2'h0} +: 4];
      end
      if (!lq.rst2) begin
         ld = '0;
         ld.rst1 = nrst;
         ld.rst2 = lq.rst1;
         ld.hr1 = halfRate;
         ld.hr2 = lq.hr1;
      end
   end

   always_ff @(posedge linkClk) begin
      lq <= ld;
   end

   assign lnk.wordStrobe = cq.strobe;
   assign lnk.serialIn = cq.serial;
   assign lnk.txNibble = lq.txNib;
   assign lnk.echoNibble = lq.echoNib;
   assign cmdReady = cq.cmdReady;
   assign sampleTake = lq.take;
   assign rxSample = lq.rxSample;
   assign rxValid = lq.rxValid;

endmodule // afe_dsp_end

// ---- tb/afe_digital_interface_chk.sv ----
// assertions on the wires between the two ends
`timescale 1ns/1ps

module afe_digital_interface_chk (
   // clocks and reset
   input wire logic core_clk,
   input wire logic linkClk,
   input wire logic nrst,
   // link wires
   input wire logic wordStrobe,
   input wire logic serialIn,
   input wire logic nibbleClk,
   input wire logic wordSignal,
   input wire logic [3:0] rxNibble,
   input wire logic [3:0] txNibble,
   input wire logic [3:0] echoNibble
);
   // strobe periods since the start bit
   logic [5:0] bitIdx_q;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         bitIdx_q <= 6'h00;
      end else if ($rose(wordStrobe)) begin
         if (bitIdx_q == 6'h00 || bitIdx_q == 6'h20) begin
            bitIdx_q <= $fell(serialIn) ? 6'h01 : 6'h00;
         end else begin
            bitIdx_q <= bitIdx_q + 6'h01;
         end
      end
   end

   chk_strobe_period: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(wordStrobe) |-> wordStrobe[*4] ##1 !wordStrobe[*4]) else $error("strobe period");
   chk_serial_launch: assert property (@(posedge core_clk) disable iff (!nrst)
      !$rose(wordStrobe) |-> $stable(serialIn)) else $error("serial moved off strobe rise");
   chk_stop_bits: assert property (@(posedge core_clk) disable iff (!nrst)
      bitIdx_q > 6'h10 && !(bitIdx_q == 6'h20 && $rose(wordStrobe)) |-> serialIn) else $error("stop bit low");
   chk_host_reset: assert property (@(posedge core_clk)
      (!nrst)[*2] |-> serialIn && !wordStrobe) else $error("host reset levels");
   chk_word_normal: assert property (@(posedge linkClk) disable iff (!nrst)
      $fell(wordSignal) && !nibbleClk && !$past(nibbleClk) |->
      (!wordSignal[*3] ##1 wordSignal) or (##[1:3] nibbleClk)) else $error("word period");
   chk_word_width: assert property (@(posedge linkClk) disable iff (!nrst)
      $rose(wordSignal) |-> ##2 !wordSignal) else $error("word width");
   chk_half_clock: assert property (@(posedge linkClk) disable iff (!nrst)
      $rose(nibbleClk) |=> !nibbleClk) else $error("nibble clock width");
   chk_reset_clocks: assert property (@(posedge linkClk)
      (!nrst)[*2] |-> nibbleClk && wordSignal) else $error("clocks not high in reset");
   chk_reset_rx: assert property (@(posedge linkClk)
      (!nrst)[*2] |-> rxNibble == 4'h0) else $error("rx lines in reset");

   cov_frame: cover property (@(posedge core_clk) disable iff (!nrst) bitIdx_q == 6'h20);
   cov_half: cover property (@(posedge linkClk) disable iff (!nrst) $rose(nibbleClk));
   cov_tx: cover property (@(posedge linkClk) disable iff (!nrst) txNibble != 4'h0 && echoNibble != 4'h0);
endmodule // afe_digital_interface_chk

// ---- tb/afe_digital_interface_tb_top.sv ----
// self-checking bench for the front end link pair
`timescale 1ns/1ps
`include "afe_params.svh"

module afe_digital_interface_tb_top;
   logic core_clk, linkClk, nrst, cmdValid, cmdReady, halfRate, sampleTake, rxValid;
   logic powerDown, testPin, siteSelect, dacValid, analogStop, routeLt;
   logic [2:0] cmdId, generalOut;
   logic [11:0] cmdData, dacTx, dacEcho, d, e;
   logic [15:0] txSample, echoSample, rxSample;
   logic [12:0] adcResult;
   wire [6:0][11:0] word;
   logic [11:0] mw [7];
   logic [15:0] lim [4];
   int n_errors, n_tests, seed;

   afe_link_if lnk();
   afe_dsp_end i_afe_dsp_end (.core_clk, .linkClk, .nrst, .lnk(lnk), .cmdValid, .cmdId, .cmdData,
      .cmdReady, .halfRate, .txSample, .echoSample, .sampleTake, .rxSample, .rxValid);
   afe_front_end i_afe_front_end (.linkClk, .nrst, .lnk(lnk), .powerDown, .testPin, .siteSelect,
      .adcResult, .dacTx, .dacEcho, .dacValid, .rxSettings(word[0]), .txSettings(word[1]),
      .feConfig(word[2]), .oscTune(word[3]), .testPowerDown(word[4]), .testOutSelect(word[5]),
      .testInSelect(word[6]), .generalOut, .analogStop, .routeLt);
   afe_digital_interface_chk i_chk (.core_clk, .linkClk, .nrst, .wordStrobe(lnk.wordStrobe),
      .serialIn(lnk.serialIn), .nibbleClk(lnk.nibbleClk), .wordSignal(lnk.wordSignal),
      .rxNibble(lnk.rxNibble), .txNibble(lnk.txNibble), .echoNibble(lnk.echoNibble));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      linkClk = 1'b0;
      #23;
      forever #80 linkClk = ~linkClk;
   end

   task complete_run;
      if (n_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task cmp(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // one command, held until cmdReady or for at most 50 core_clk cycles, then wait for idle
   task send(input logic [2:0] id, input logic [11:0] v);
      int k;
      cmdId <= id;
      cmdData <= v;
      cmdValid <= 1'b1;
      k = 0;
      do begin @(posedge core_clk); k++; end while (cmdReady !== 1'b1 && k < 50);
      cmdValid <= 1'b0;
      do begin @(posedge core_clk); k++; end while (cmdReady !== 1'b1 && k < 450);
      cmp(cmdReady, 1'b1);
      cyc(20);
   endtask

   task chkw;
      for (int i = 0; i < 7; i++) cmp(word[i], (i > 3 && !testPin) ? 12'h000 : mw[i]);
   endtask

   function automatic logic [11:0] clampv(input logic [15:0] s);
      return (s[15] == s[14]) ? s[14:3] : (s[15] ? 12'h800 : 12'h7FF);
   endfunction

   task smp(input int w);
      for (int i = 0; i < 4; i++) begin
         @(posedge linkClk);
         txSample <= 16'($random(seed));
         echoSample <= lim[i];
         adcResult <= 13'($random(seed));
         repeat (w) @(posedge linkClk);
         @(posedge linkClk iff dacValid);
         cmp(dacTx, clampv(txSample));
         cmp(dacEcho, clampv(echoSample));
         @(posedge linkClk iff rxValid);
         cmp(rxSample, {adcResult[12], adcResult, 2'b00});
      end
   endtask

   initial begin
      #3000000;
      n_errors++;
      complete_run;
   end

   initial begin
      seed = 32'h504D;
      n_errors = 0;
      n_tests = 0;
      nrst = 1'b0;
      cmdValid = 1'b0;
      cmdId = 3'h0;
      cmdData = 12'h000;
      halfRate = 1'b0;
      txSample = 16'h0000;
      echoSample = 16'h0000;
      powerDown = 1'b0;
      testPin = 1'b0;
      siteSelect = 1'b1;
      adcResult = 13'h0000;
      lim = '{16'h3FFF, 16'h4000, 16'hC000, 16'hBFFF};
      mw = '{`RST_RX, `RST_TX, `RST_CFG, `RST_TUNE, `RST_TEST, `RST_TEST, `RST_TEST};
      cyc(10);
      nrst <= 1'b1;
      cyc(8);
      chkw;
      cmp(routeLt, 1'b1);
      testPin <= 1'b1;
      cyc(8);
      for (int i = 0; i < 8; i++) begin
         d = 12'($random(seed));
         if (i == 2) d = d & 12'h77F;
         send(i[2:0], d);
         if (i < 7) mw[i] = d;
         chkw;
         cmp(generalOut, mw[1][3:1]);
      end
      testPin <= 1'b0;
      cyc(8);
      chkw;
      testPin <= 1'b1;
      cyc(8);
      chkw;
      smp(24);
      @(posedge linkClk);
      powerDown <= 1'b1;
      repeat (8) @(posedge linkClk);
      cmp(analogStop, 1'b1);
      e = clampv(txSample);
      txSample <= ~txSample;
      repeat (24) @(posedge linkClk);
      cmp(dacTx, e);
      chkw;
      powerDown <= 1'b0;
      repeat (8) @(posedge linkClk);
      d = mw[2] | 12'h080;
      send(`ID_CFG, d);
      mw[2] = d;
      halfRate <= 1'b1;
      smp(48);
      e = clampv(txSample);
      d = mw[2] | 12'h800;
      send(`ID_CFG, d);
      mw[2] = d;
      @(posedge linkClk iff rxValid);
      cmp(rxSample, {e[11], e, 3'h0});
      chkw;
      complete_run;
   end
endmodule // afe_digital_interface_tb_top
